// ===== src/ctm_core.sv
// instruction cycle timing sequencer: holds each instruction for its
// e-cycle count, fetches vectors into the program counter
// assumes a same-clock decoder issues req_valid only while ready_q is high;
// memory answers a read within one core clock of the address settling
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.svh"
module ctm_core
   import ctm_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire ctm_req_s req,
   input wire ctm_alu_s alu,
   input wire logic irq_n,
   input wire logic [7:0] mem_rdata,
   output logic ready_q,
   output logic done_q,
   output logic bad_mode_q,
   output logic branch_taken_q,
   output logic wait_idle_q,
   output logic [15:0] pc_q,
   output ctm_bus_s bus_q,
   output logic e_clk_q,
   output logic [7:0] ccr_q
);

   ////////////////////////////////////////////////////////////////////////
   // cycle table

   function automatic logic [3:0] ctm_cycles(input ctm_op_e op,
                                             input ctm_mode_e md);
      logic [3:0] n;
      n = 4'h0;
      case (op)
         OP_ALU8: begin
            case (md)
               MODE_IMM: n = `CTM_CYC_ALU8_IMM;
               MODE_DIR: n = `CTM_CYC_ALU8_DIR;
               MODE_IDX, MODE_EXT: n = `CTM_CYC_ALU8_IDX;
               default: n = 4'h0;
            endcase
         end
         OP_DOUBLE_ADD: begin
            case (md)
               MODE_IMM: n = `CTM_CYC_ADD16_IMM;
               MODE_DIR: n = `CTM_CYC_ADD16_DIR;
               MODE_IDX, MODE_EXT: n = `CTM_CYC_ADD16_IDX;
               default: n = 4'h0;
            endcase
         end
         OP_DOUBLE_LOAD: begin
            case (md)
               MODE_IMM: n = `CTM_CYC_LD16_IMM;
               MODE_DIR: n = `CTM_CYC_LD16_DIR;
               MODE_IDX, MODE_EXT: n = `CTM_CYC_LD16_IDX;
               default: n = 4'h0;
            endcase
         end
         OP_DOUBLE_STORE: begin
            case (md)
               MODE_DIR: n = `CTM_CYC_ST16_DIR;
               MODE_IDX, MODE_EXT: n = `CTM_CYC_ST16_IDX;
               default: n = 4'h0;
            endcase
         end
         OP_ARITH_SHIFT_LEFT: begin
            case (md)
               MODE_IDX, MODE_EXT: n = `CTM_CYC_RMW_MEM;
               MODE_INH: n = `CTM_CYC_RMW_INH;
               default: n = 4'h0;
            endcase
         end
         OP_BRANCH_ALWAYS, OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_NOT_EQUAL: begin
            n = (md == MODE_REL) ? `CTM_CYC_BRANCH : 4'h0;
         end
         OP_BRANCH_TO_SUBROUTINE: begin
            n = (md == MODE_REL) ? `CTM_CYC_BSUB : 4'h0;
         end
         OP_JUMP_TO_SUBROUTINE: begin
            case (md)
               MODE_DIR: n = `CTM_CYC_JSUB_DIR;
               MODE_IDX, MODE_EXT: n = `CTM_CYC_JSUB_IDX;
               default: n = 4'h0;
            endcase
         end
         OP_JUMP: begin
            n = (md == MODE_IDX || md == MODE_EXT) ? `CTM_CYC_JUMP : 4'h0;
         end
         OP_MULTIPLY: n = (md == MODE_INH) ? `CTM_CYC_MULT : 4'h0;
         OP_SOFTWARE_INTERRUPT: n = (md == MODE_INH) ? `CTM_CYC_SOFTI : 4'h0;
         OP_RETURN_FROM_INTERRUPT: n = (md == MODE_INH) ? `CTM_CYC_RETI : 4'h0;
         OP_RETURN_FROM_SUBROUTINE: n = (md == MODE_INH) ? `CTM_CYC_RTS : 4'h0;
         OP_WAIT_FOR_INTERRUPT: n = (md == MODE_INH) ? `CTM_CYC_WAITI : 4'h0;
         OP_PUSH_ACCUMULATOR: n = (md == MODE_INH) ? `CTM_CYC_PUSH_ACC : 4'h0;
         OP_PULL_ACCUMULATOR: n = (md == MODE_INH) ? `CTM_CYC_PULL_ACC : 4'h0;
         OP_PUSH_INDEX: n = (md == MODE_INH) ? `CTM_CYC_PUSH_IDX : 4'h0;
         OP_PULL_INDEX: n = (md == MODE_INH) ? `CTM_CYC_PULL_IDX : 4'h0;
         OP_ADD_B_TO_INDEX, OP_INDEX_STEP: begin
            n = (md == MODE_INH) ? `CTM_CYC_IDX_ARITH : 4'h0;
         end
         OP_DOUBLE_SHIFT_LEFT, OP_DOUBLE_SHIFT_RIGHT: begin
            n = (md == MODE_INH) ? `CTM_CYC_DSHIFT : 4'h0;
         end
         default: n = 4'h0;
      endcase
      return n;
   endfunction : ctm_cycles

   ////////////////////////////////////////////////////////////////////////
   // divider, flags, pin synchronisers

   logic e_tick;
   logic irq_n_s1_q;
   logic irq_n_s2_q;
   logic [7:0] rdata_s1_q;
   logic [7:0] rdata_s2_q;

   ctm_ediv u_ediv (
      .core_clk(core_clk),
      .reset(reset),
      .e_tick_q(e_tick),
      .e_clk_q(e_clk_q)
   );

   ctm_flags u_flags (
      .core_clk(core_clk),
      .reset(reset),
      .alu(alu),
      .ccr_q(ccr_q)
   );

   // both come from pins, so two flops before use
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_n_s1_q <= 1'b1;
         irq_n_s2_q <= 1'b1;
         rdata_s1_q <= 8'h00;
         rdata_s2_q <= 8'h00;
      end else begin
         irq_n_s1_q <= irq_n;
         irq_n_s2_q <= irq_n_s1_q;
         rdata_s1_q <= mem_rdata;
         rdata_s2_q <= rdata_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode of the request and of the running op

   wire logic irq_req = ~irq_n_s2_q;
   wire logic [3:0] req_cyc = ctm_cycles(req.op, req.mode);
   wire logic req_take = req_valid & ready_q;
   wire logic req_soft = (req.op == OP_SOFTWARE_INTERRUPT);
   // the last two e-cycles of a software interrupt are the vector fetch
   wire logic [3:0] req_tgt = req_soft ? (req_cyc - `CTM_CYC_VEC) : req_cyc;

   ctm_state_e state_q;
   ctm_state_e state_d;
   ctm_op_e op_q;
   ctm_op_e op_d;
   ctm_vec_kind_e vk_q;
   ctm_vec_kind_e vk_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] tgt_q;
   logic [3:0] tgt_d;
   logic pend_q;
   logic pend_d;
   logic svc_q;
   logic svc_d;
   logic [7:0] hi_q;
   logic [7:0] hi_d;
   logic ready_d;
   logic done_d;
   logic bad_d;
   logic taken_d;
   logic wait_d;
   logic [15:0] pc_d;
   ctm_bus_s bus_d;

   wire logic zero_flag = ccr_q[`CTM_Z_BIT];
   wire logic last_cyc = (cnt_q == tgt_q);
   wire logic op_is_soft = (op_q == OP_SOFTWARE_INTERRUPT);
   wire logic branch_hit = (op_q == OP_BRANCH_ALWAYS) |
                           ((op_q == OP_BRANCH_IF_EQUAL) & zero_flag) |
                           ((op_q == OP_BRANCH_IF_NOT_EQUAL) & ~zero_flag);

   wire logic [15:0] vec_addr = (state_q == ST_RST) ? `CTM_RESET_VEC :
                                (state_q == ST_EXEC && !svc_q) ?
                                `CTM_SOFTI_VEC : `CTM_IRQ_VEC;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      vk_d = vk_q;
      cnt_d = cnt_q;
      tgt_d = tgt_q;
      pend_d = pend_q;
      svc_d = svc_q;
      hi_d = hi_q;
      ready_d = ready_q;
      done_d = 1'b0;
      bad_d = 1'b0;
      taken_d = 1'b0;
      wait_d = wait_idle_q;
      pc_d = pc_q;
      bus_d = bus_q;

      // a request with no table entry is refused at once
      if (req_take) begin
         if (req_cyc == 4'h0) begin
            bad_d = 1'b1;
         end else begin
            pend_d = 1'b1;
            ready_d = 1'b0;
            op_d = req.op;
            tgt_d = req_tgt;
         end
      end

      if (e_tick) begin
         case (state_q)
            ST_RST: begin
               vk_d = VK_RESET;
               state_d = ST_VEC_HI;
            end
            ST_IDLE: begin
               if (pend_q) begin
                  pend_d = 1'b0;
                  cnt_d = 4'h1;
                  state_d = ST_EXEC;
               end else if (irq_req && !req_take) begin
                  // hardware interrupt: stack like a software one
                  svc_d = 1'b1;
                  ready_d = 1'b0;
                  op_d = OP_SOFTWARE_INTERRUPT;
                  tgt_d = `CTM_CYC_SOFTI - `CTM_CYC_VEC;
                  cnt_d = 4'h1;
                  state_d = ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (!last_cyc) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (op_is_soft) begin
                  vk_d = svc_q ? VK_IRQ : VK_SOFT;
                  state_d = ST_VEC_HI;
               end else if (op_q == OP_WAIT_FOR_INTERRUPT) begin
                  done_d = 1'b1;
                  wait_d = 1'b1;
                  state_d = ST_WAIT;
               end else begin
                  taken_d = branch_hit;
                  done_d = 1'b1;
                  ready_d = 1'b1;
                  state_d = ST_IDLE;
               end
            end
            ST_WAIT: begin
               // stacking was done before idling, so go straight to vector
               if (irq_req) begin
                  wait_d = 1'b0;
                  vk_d = VK_IRQ;
                  state_d = ST_VEC_HI;
               end
            end
            ST_VEC_HI: begin
               hi_d = rdata_s2_q;
               bus_d.addr = bus_q.addr + 16'h0001;
               state_d = ST_VEC_LO;
            end
            ST_VEC_LO: begin
               pc_d = {hi_q, rdata_s2_q};
               bus_d.rd = 1'b0;
               done_d = (vk_q == VK_SOFT);
               svc_d = 1'b0;
               ready_d = 1'b1;
               state_d = ST_IDLE;
            end
            default: state_d = ST_RST;
         endcase
      end

      // the read address goes out at the start of the fetch e-cycle
      if (e_tick && state_d == ST_VEC_HI && state_q != ST_VEC_HI) begin
         bus_d.addr = vec_addr;
         bus_d.rd = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= ST_RST;
         op_q <= OP_ALU8;
         vk_q <= VK_RESET;
         cnt_q <= 4'h0;
         tgt_q <= 4'h0;
         pend_q <= 1'b0;
         svc_q <= 1'b0;
         hi_q <= 8'h00;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         vk_q <= vk_d;
         cnt_q <= cnt_d;
         tgt_q <= tgt_d;
         pend_q <= pend_d;
         svc_q <= svc_d;
         hi_q <= hi_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ready_q <= 1'b0;
         done_q <= 1'b0;
         bad_mode_q <= 1'b0;
         branch_taken_q <= 1'b0;
         wait_idle_q <= 1'b0;
         pc_q <= 16'h0000;
         bus_q <= '0;
      end else begin
         ready_q <= ready_d;
         done_q <= done_d;
         bad_mode_q <= bad_d;
         branch_taken_q <= taken_d;
         wait_idle_q <= wait_d;
         pc_q <= pc_d;
         bus_q <= bus_d;
      end
   end

endmodule : ctm_core
`default_nettype wire

// ===== src/ctm_defs.svh
// constants for the instruction cycle timing sequencer
// assumes a 25 MHz core clock and one e-cycle of four core clocks
//
// Operation
// - 8-bit accumulator memory ops: 2 imm, 3 dir, 4 idx, 4 ext
// - double add: 4 imm, 5 dir, 6 idx and ext
// - double load: 3 imm, 4 dir, 5 idx or ext
// - double store: no immediate form; 4 dir, 5 idx or ext
// - read-modify-write: 6 idx or ext; accumulator inherent form 2
// - every conditional branch and branch-always take 3, taken or not
// - relative branch to subroutine takes 6
// - jump to subroutine 5 dir, 6 idx or ext; plain jump 3
// - unsigned 8x8 multiply is inherent, 10 cycles
// - software interrupt with stacking and vector fetch takes 12
// - return from interrupt 10, return from subroutine 5
// - wait-for-interrupt spends 9 before idling
// - push accumulator 3, pull 4; push index 4, pull 5
// - add b to index, index or stack inc/dec: 3 each
// - double logical shifts left and right: 3, inherent
// - overflow flag at bit 1 set on two's complement overflow
// - zero flag at bit 2 set on zero result; equal branches test it
// - program counter loaded from vector of the causing condition
// - one e-cycle lasts four input clock periods
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH

`define CTM_E_DIV 4
`define CTM_RESET_VEC 16'hFFFE
`define CTM_SOFTI_VEC 16'hFFFA
`define CTM_IRQ_VEC 16'hFFF8
`define CTM_V_BIT 1
`define CTM_Z_BIT 2
`define CTM_CYC_VEC 4'h2
`define CTM_CYC_ALU8_IMM 4'h2
`define CTM_CYC_ALU8_DIR 4'h3
`define CTM_CYC_ALU8_IDX 4'h4
`define CTM_CYC_ADD16_IMM 4'h4
`define CTM_CYC_ADD16_DIR 4'h5
`define CTM_CYC_ADD16_IDX 4'h6
`define CTM_CYC_LD16_IMM 4'h3
`define CTM_CYC_LD16_DIR 4'h4
`define CTM_CYC_LD16_IDX 4'h5
`define CTM_CYC_ST16_DIR 4'h4
`define CTM_CYC_ST16_IDX 4'h5
`define CTM_CYC_RMW_MEM 4'h6
`define CTM_CYC_RMW_INH 4'h2
`define CTM_CYC_BRANCH 4'h3
`define CTM_CYC_BSUB 4'h6
`define CTM_CYC_JSUB_DIR 4'h5
`define CTM_CYC_JSUB_IDX 4'h6
`define CTM_CYC_JUMP 4'h3
`define CTM_CYC_MULT 4'hA
`define CTM_CYC_SOFTI 4'hC
`define CTM_CYC_RETI 4'hA
`define CTM_CYC_RTS 4'h5
`define CTM_CYC_WAITI 4'h9
`define CTM_CYC_PUSH_ACC 4'h3
`define CTM_CYC_PULL_ACC 4'h4
`define CTM_CYC_PUSH_IDX 4'h4
`define CTM_CYC_PULL_IDX 4'h5
`define CTM_CYC_IDX_ARITH 4'h3
`define CTM_CYC_DSHIFT 4'h3

`endif

// ===== src/ctm_pkg.sv
// types for the instruction cycle timing sequencer
// assumes the opcode decoder upstream has already sorted opcodes by class
package ctm_pkg;

   typedef enum logic [4:0] {
      OP_ALU8, OP_DOUBLE_ADD, OP_DOUBLE_LOAD, OP_DOUBLE_STORE,
      OP_ARITH_SHIFT_LEFT, OP_BRANCH_ALWAYS, OP_BRANCH_IF_EQUAL,
      OP_BRANCH_IF_NOT_EQUAL, OP_BRANCH_TO_SUBROUTINE,
      OP_JUMP_TO_SUBROUTINE, OP_JUMP, OP_MULTIPLY, OP_SOFTWARE_INTERRUPT,
      OP_RETURN_FROM_INTERRUPT, OP_RETURN_FROM_SUBROUTINE,
      OP_WAIT_FOR_INTERRUPT, OP_PUSH_ACCUMULATOR, OP_PULL_ACCUMULATOR,
      OP_PUSH_INDEX, OP_PULL_INDEX, OP_ADD_B_TO_INDEX, OP_INDEX_STEP,
      OP_DOUBLE_SHIFT_LEFT, OP_DOUBLE_SHIFT_RIGHT
   } ctm_op_e;

   typedef enum logic [2:0] {
      MODE_IMM, MODE_DIR, MODE_IDX, MODE_EXT, MODE_INH, MODE_REL
   } ctm_mode_e;

   typedef enum logic [2:0] {
      ST_RST, ST_IDLE, ST_EXEC, ST_WAIT, ST_VEC_HI, ST_VEC_LO
   } ctm_state_e;

   typedef enum logic [1:0] {VK_RESET, VK_SOFT, VK_IRQ} ctm_vec_kind_e;

   typedef struct packed {
      ctm_op_e op;
      ctm_mode_e mode;
   } ctm_req_s;

   typedef struct packed {
      logic upd;
      logic wide;
      logic ovf;
      logic [15:0] res;
   } ctm_alu_s;

   typedef struct packed {
      logic rd;
      logic [15:0] addr;
   } ctm_bus_s;

endpackage : ctm_pkg

// ===== src/ctm_ediv.sv
// e-cycle divider: one e_tick per four core clocks, plus the e pin level
// assumes core_clk is the crystal-rate input clock
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.svh"
module ctm_ediv
   import ctm_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   output logic e_tick_q,
   output logic e_clk_q
);
   logic [1:0] ph_q;
   wire logic [1:0] ph_last = 2'(`CTM_E_DIV - 1);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ph_q <= 2'h0;
         e_tick_q <= 1'b0;
         e_clk_q <= 1'b0;
      end else begin
         ph_q <= ph_q + 2'h1;
         e_tick_q <= (ph_q == ph_last - 2'h1);
         // high two clocks, falls right after the e_tick cycle
         e_clk_q <= (ph_q == 2'h1) | (ph_q == 2'h2);
      end
   end
endmodule : ctm_ediv
`default_nettype wire

// ===== src/ctm_flags.sv
// condition code register: overflow and zero flags from the alu result
// assumes alu results arrive from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.svh"
module ctm_flags
   import ctm_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire ctm_alu_s alu,
   output logic [7:0] ccr_q
);
   // a byte op only looks at the low byte for zero
   wire logic res_zero = alu.wide ? (alu.res == 16'h0000)
                                  : (alu.res[7:0] == 8'h00);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ccr_q <= 8'h00;
      end else if (alu.upd) begin
         ccr_q[`CTM_V_BIT] <= alu.ovf;
         ccr_q[`CTM_Z_BIT] <= res_zero;
      end
   end
endmodule : ctm_flags
`default_nettype wire

// ===== dv/ctm_mem_model.sv
// memory model on the far side of the vector fetch bus
// assumes reads are flagged by bus.rd and answered one clock later
`timescale 1ns/100ps
`default_nettype none
module ctm_mem_model
   import ctm_pkg::*;
(
   input wire logic core_clk,
   input wire ctm_bus_s bus,
   output logic [7:0] rdata
);
   initial rdata = 8'h3C;
   always @(posedge core_clk) begin
      if (bus.rd) begin
         rdata <= bus.addr[7:0] ^ 8'hA5;
      end else begin
         // released bus: a stale byte must never look valid
         rdata <= ~rdata;
      end
   end
endmodule : ctm_mem_model
`default_nettype wire

// ===== dv/ctm_core_assertions.sv
// port-level checker for the cycle timing sequencer
// assumes it is bound onto ctm_core and sees its ports only
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.svh"
module ctm_core_chk
   import ctm_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire ctm_req_s req,
   input wire ctm_alu_s alu,
   input wire logic ready_q,
   input wire logic done_q,
   input wire logic bad_mode_q,
   input wire logic branch_taken_q,
   input wire ctm_bus_s bus_q,
   input wire logic e_clk_q,
   input wire logic [7:0] ccr_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire logic take = ready_q && req_valid;
   ////////////////////////////////////////////////////////////////////////
   property p_e_period;
      $rose(e_clk_q) |=> e_clk_q ##1 !e_clk_q ##1 !e_clk_q ##1 e_clk_q;
   endproperty
   a_e_period: assert property (p_e_period)
      else $error("e pin period wrong");
   property p_flag_v;
      alu.upd |=> ccr_q[`CTM_V_BIT] == $past(alu.ovf);
   endproperty
   a_flag_v: assert property (p_flag_v)
      else $error("overflow flag wrong");
   property p_flag_z;
      alu.upd |=> ccr_q[`CTM_Z_BIT] == ($past(alu.wide) ?
         ($past(alu.res) == 16'h0000) : ($past(alu.res[7:0]) == 8'h00));
   endproperty
   a_flag_z: assert property (p_flag_z)
      else $error("zero flag wrong");
   property p_store_imm;
      take && req.op == OP_DOUBLE_STORE && req.mode == MODE_IMM
         |=> bad_mode_q && ready_q;
   endproperty
   a_store_imm: assert property (p_store_imm)
      else $error("store immediate not refused");
   property p_bad_ready;
      bad_mode_q |-> ready_q && !done_q;
   endproperty
   a_bad_ready: assert property (p_bad_ready)
      else $error("refusal disturbed ready");
   property p_branch_done;
      branch_taken_q |-> done_q;
   endproperty
   a_branch_done: assert property (p_branch_done)
      else $error("branch taken outside done");
   // start waits one to four clocks for the e-cycle edge, then 4 per cycle
   property p_mult_len;
      take && req.op == OP_MULTIPLY && req.mode == MODE_INH
         |=> !ready_q ##[41:44] done_q;
   endproperty
   a_mult_len: assert property (p_mult_len)
      else $error("multiply length wrong");
   property p_soft_int_len;
      take && req.op == OP_SOFTWARE_INTERRUPT && req.mode == MODE_INH
         |=> !ready_q ##[49:52] done_q;
   endproperty
   a_soft_int_len: assert property (p_soft_int_len)
      else $error("software interrupt length wrong");
   property p_vec_pair;
      $rose(bus_q.rd) |-> bus_q.addr inside {`CTM_RESET_VEC, `CTM_SOFTI_VEC,
         `CTM_IRQ_VEC} ##4 (bus_q.rd && bus_q.addr == $past(bus_q.addr, 4)
         + 16'h0001);
   endproperty
   a_vec_pair: assert property (p_vec_pair)
      else $error("vector fetch order wrong");
endmodule : ctm_core_chk
bind ctm_core ctm_core_chk u_chk (
   .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req(req),
   .alu(alu), .ready_q(ready_q), .done_q(done_q), .bad_mode_q(bad_mode_q),
   .branch_taken_q(branch_taken_q), .bus_q(bus_q), .e_clk_q(e_clk_q),
   .ccr_q(ccr_q)
);
`default_nettype wire

// ===== dv/ctm_core_tb.sv
// self-checking bench for the cycle timing sequencer
// assumes the memory model answers vector reads within one clock
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.svh"
module ctm_core_tb
   import ctm_pkg::*;
;
   logic core_clk, reset, req_valid, irq_n, z_exp;
   ctm_req_s req;
   ctm_alu_s alu;
   logic ready_q, done_q, bad_mode_q, branch_taken_q, wait_idle_q, e_clk_q;
   logic [15:0] pc_q;
   ctm_bus_s bus_q;
   logic [7:0] ccr_q, mem_rdata;
   int failures = 0;
   int n_tests = 0;
   ctm_core DUT (
      .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req(req),
      .alu(alu), .irq_n(irq_n), .mem_rdata(mem_rdata), .ready_q(ready_q),
      .done_q(done_q), .bad_mode_q(bad_mode_q), .wait_idle_q(wait_idle_q),
      .branch_taken_q(branch_taken_q), .pc_q(pc_q), .bus_q(bus_q),
      .e_clk_q(e_clk_q), .ccr_q(ccr_q)
   );
   ctm_mem_model u_mem (.core_clk(core_clk), .bus(bus_q), .rdata(mem_rdata));
   initial begin
      core_clk = 0;
      forever #20 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task automatic step(inout int k);
      @(negedge core_clk);
      k++;
      if (k > 300) begin
         failures++;
         finish_test();
      end
   endtask : step
   task automatic wait_ready();
      int k = 0;
      while (ready_q !== 1'b1) step(k);
   endtask : wait_ready
   function automatic logic [15:0] vec_val(input logic [15:0] a);
      return {a[7:0] ^ 8'hA5, (a[7:0] + 8'h01) ^ 8'hA5};
   endfunction : vec_val
   function automatic int pick(input ctm_mode_e m, input int a, b, c, d,
                               input int e, f);
      int t[6];
      t = '{a, b, c, d, e, f};
      return t[m];
   endfunction : pick
   // expected e-cycles per op and mode; 0 means no entry
   function automatic int exp_n(input ctm_op_e op, input ctm_mode_e m);
      case (op)
         OP_ALU8: return pick(m, 2, 3, 4, 4, 0, 0);
         OP_DOUBLE_ADD: return pick(m, 4, 5, 6, 6, 0, 0);
         OP_DOUBLE_LOAD: return pick(m, 3, 4, 5, 5, 0, 0);
         OP_DOUBLE_STORE: return pick(m, 0, 4, 5, 5, 0, 0);
         OP_ARITH_SHIFT_LEFT: return pick(m, 0, 0, 6, 6, 2, 0);
         OP_BRANCH_ALWAYS, OP_BRANCH_IF_EQUAL,
            OP_BRANCH_IF_NOT_EQUAL: return pick(m, 0, 0, 0, 0, 0, 3);
         OP_BRANCH_TO_SUBROUTINE: return pick(m, 0, 0, 0, 0, 0, 6);
         OP_JUMP_TO_SUBROUTINE: return pick(m, 0, 5, 6, 6, 0, 0);
         OP_JUMP: return pick(m, 0, 0, 3, 3, 0, 0);
         OP_MULTIPLY: return pick(m, 0, 0, 0, 0, 10, 0);
         OP_SOFTWARE_INTERRUPT: return pick(m, 0, 0, 0, 0, 12, 0);
         OP_RETURN_FROM_INTERRUPT:
            return pick(m, 0, 0, 0, 0, 10, 0);
         OP_RETURN_FROM_SUBROUTINE:
            return pick(m, 0, 0, 0, 0, 5, 0);
         OP_WAIT_FOR_INTERRUPT: return pick(m, 0, 0, 0, 0, 9, 0);
         OP_PULL_ACCUMULATOR, OP_PUSH_INDEX:
            return pick(m, 0, 0, 0, 0, 4, 0);
         OP_PULL_INDEX: return pick(m, 0, 0, 0, 0, 5, 0);
         OP_PUSH_ACCUMULATOR, OP_ADD_B_TO_INDEX, OP_INDEX_STEP,
            OP_DOUBLE_SHIFT_LEFT, OP_DOUBLE_SHIFT_RIGHT:
            return pick(m, 0, 0, 0, 0, 3, 0);
         default: return 0;
      endcase
   endfunction : exp_n
   function automatic logic exp_tk(input ctm_op_e op);
      return op == OP_BRANCH_ALWAYS || (op == OP_BRANCH_IF_EQUAL && z_exp)
         || (op == OP_BRANCH_IF_NOT_EQUAL && !z_exp);
   endfunction : exp_tk
   ////////////////////////////////////////////////////////////////////////
   // one request; poke sends an illegal request while busy
   task automatic do_op(input ctm_op_e op, input ctm_mode_e md,
                        input bit poke);
      int n;
      int k;
      n = exp_n(op, md);
      wait_ready();
      req_valid = 1;
      req = '{op: op, mode: md};
      @(negedge core_clk);
      req_valid = 0;
      k = 1;
      if (n == 0) begin
         check("refused", {bad_mode_q, ready_q}, 2'b11);
         // let an edge pass so the next request is not raised at once
         @(negedge core_clk);
         return;
      end
      check("ready_drop", ready_q, 1'b0);
      while (done_q !== 1'b1) begin
         if (poke && k == 3) begin
            req_valid = 1;
            req.mode = MODE_IMM;
         end
         if (poke && k == 4) begin
            req_valid = 0;
            check("busy_ignored", bad_mode_q, 1'b0);
         end
         step(k);
      end
      // start waits one to four clocks for the next e-cycle edge
      check("e_cycles", (k - 2) / 4, n); // to
      check("taken", branch_taken_q, exp_tk(op));
      check("ready_back", ready_q, op != OP_WAIT_FOR_INTERRUPT);
      if (op == OP_SOFTWARE_INTERRUPT)
         check("soft_int_pc", pc_q, vec_val(`CTM_SOFTI_VEC));
      if (op == OP_WAIT_FOR_INTERRUPT) begin
         @(negedge core_clk);
         check("idle", wait_idle_q, 1'b1);
         irq_n = 0;
         k = 0;
         while (bus_q.rd !== 1'b1) step(k);
         irq_n = 1;
         wait_ready();
         check("irq_pc", pc_q, vec_val(`CTM_IRQ_VEC));
      end
   endtask : do_op
   task automatic t_reset_vec();
      wait_ready();
      check("reset_pc", pc_q, vec_val(`CTM_RESET_VEC));
      check("reset_ccr", ccr_q, 8'h00);
   endtask : t_reset_vec
   // interrupt pin while idle: stacks, then fetches its own vector
   task automatic t_irq_idle();
      int k = 0;
      irq_n = 0;
      while (bus_q.rd !== 1'b1) step(k);
      irq_n = 1;
      check("irq_addr", bus_q.addr, `CTM_IRQ_VEC);
      check("irq_busy", ready_q, 1'b0);
      wait_ready();
      check("irq_idle_pc", pc_q, vec_val(`CTM_IRQ_VEC));
      check("irq_no_done", done_q, 1'b0);
   endtask : t_irq_idle
   task automatic t_all_ops();
      z_exp = 0;
      for (int i = 0; i < 24; i++)
         for (int m = 0; m < 6; m++)
            do_op(ctm_op_e'(i), ctm_mode_e'(m), 1'b0);
   endtask : t_all_ops
   task automatic t_flags();
      alu = '{upd: 1'b1, wide: 1'b0, ovf: 1'b0, res: 16'h0100};
      @(negedge core_clk);
      alu.upd = 0;
      check("zero_byte", ccr_q, 8'h04);
      z_exp = 1;
      do_op(OP_BRANCH_IF_EQUAL, MODE_REL, 1'b0);
      do_op(OP_BRANCH_IF_NOT_EQUAL, MODE_REL, 1'b0);
      alu = '{upd: 1'b1, wide: 1'b1, ovf: 1'b1, res: 16'h0100};
      @(negedge core_clk);
      alu.upd = 0;
      check("ovf_wide", ccr_q, 8'h02);
      z_exp = 0;
      do_op(OP_BRANCH_IF_EQUAL, MODE_REL, 1'b0);
   endtask : t_flags
   initial begin
      reset = 1;
      req_valid = 0;
      irq_n = 1;
      req = '{op: OP_ALU8, mode: MODE_IMM};
      alu = '0;
      z_exp = 0;
      repeat (8) @(negedge core_clk);
      reset = 0;
      t_reset_vec();
      t_irq_idle();
      t_all_ops();
      do_op(OP_MULTIPLY, MODE_INH, 1'b1);
      t_flags();
      finish_test();
   end
endmodule : ctm_core_tb
`default_nettype wire
